// ---- rtl/bac_defines.vh ----
// Constants for the station address and serial framing loader.
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus.
`ifndef BAC_DEFINES_VH
`define BAC_DEFINES_VH

// ==========================================================================
// Clock and baud rates
`define BAC_CLK_HZ        20000000
`define BAC_BIT_9600      (`BAC_CLK_HZ / 9600)
`define BAC_BIT_19200     (`BAC_CLK_HZ / 19200)
`define BAC_BIT_38400     (`BAC_CLK_HZ / 38400)
`define BAC_BIT_57600     (`BAC_CLK_HZ / 57600)
`define BAC_BIT_76800     (`BAC_CLK_HZ / 76800)
`define BAC_BIT_115200    (`BAC_CLK_HZ / 115200)
`define BAC_RUN_W         15
`define BAC_RUN_MAX       15'h7fff
`define BAC_PULSES        4'h8

// ==========================================================================
// Framing code: [2:0] baud index, [4:3] parity, [5] two stop bits
`define BAC_FR_W          6
`define BAC_FR_BAUD       2:0
`define BAC_FR_PAR        4:3
`define BAC_FR_STOP2      5
`define BAC_BAUD_9600     3'h0
`define BAC_BAUD_19200    3'h1
`define BAC_BAUD_38400    3'h2
`define BAC_BAUD_57600    3'h3
`define BAC_BAUD_76800    3'h4
`define BAC_BAUD_115200   3'h5
`define BAC_PAR_NONE      2'h0
`define BAC_PAR_EVEN      2'h1
`define BAC_PAR_ODD       2'h2
`define BAC_TRY_LAST      2'h2

// ==========================================================================
// Address ranges and option switch positions
`define BAC_BLD_ADR_MIN   8'h00
`define BAC_BLD_ADR_MAX   8'h7f
`define BAC_REG_ADR_MIN   8'h01
`define BAC_REG_ADR_MAX   8'hf7
`define BAC_OPT_MENU      0
`define BAC_OPT_PROTO     1

// ==========================================================================
// Display tags
`define BAC_TXT_ADDR      2'h1
`define BAC_TXT_ERR       2'h2
`define BAC_TXT_NONE      2'h0
`define BAC_TAG_BLD       2'h1
`define BAC_TAG_REG       2'h2

// ==========================================================================
// Register map (byte addresses)
`define BAC_REG_STATUS    4'h0
`define BAC_REG_FRAMING   4'h4
`define BAC_REG_MANUAL    4'h8
`define BAC_MAN_EN        8
`define BAC_ST_VALID      8
`define BAC_ST_PROTO      9
`define BAC_ST_MENU       10
`define BAC_ST_DONE       11
`define BAC_ST_DETECT     12
`define BAC_ST_HALT       13

`endif

// ---- rtl/bac_config.v ----
// Power-up configuration loader: station address, options, framing detection.
// Assumes switches read 1 for ON, an external serial engine reporting messages,
// and a non-volatile store presenting any saved framing from reset onward.
// The serial line idles high and is taken as synchronous to the clock.
//
// Operation
// - Address is sum of ON switch weights, 128 for position 1 down to 1.
// - Building protocol accepts addresses 0 through 127 only.
// - Register protocol accepts addresses 1 through 247 only.
// - Power-up display: address value, address tag, protocol tag secondary.
// - Invalid address: show the value with the error tag.
// - Option position 1 ON permits menu entry, OFF blocks it.
// - Option position 2 ON selects register protocol; position 3 unused.
// - Baud, parity and stop bits are found from bus traffic.
// - Building: 9600 8N1; register: 19200 to 115200, E1, O1 or N2 (the classifier also yields 9600 under register).
// - With a valid address, start watching the bus after power-up.
// - Requests may go unanswered while detection is in progress.
// - Detection ends only on an error-free message to this node.
// - Detected framing is saved and reused at every later start.
// - Detection restarts only after a power cycle.
// - Menu entry needs the enable switch and an attached display.
//
// Design decisions made here: the Wishbone register port and the register addresses.
`include "bac_defines.vh"

module bac_config (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone slave
   input  wire [3:0]  wb_adr_i,
   input  wire [31:0] wb_dat_i,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_we_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Switch banks and display presence
   input  wire [7:0]  address_switch_bank_i,
   input  wire [3:0]  option_switch_bank_i,
   input  wire        display_present_i,
   // Serial line and message engine
   input  wire        rxd_i,
   input  wire        msg_ok_i,
   input  wire        msg_err_i,
   input  wire [7:0]  msg_addr_i,
   // Non-volatile store
   input  wire        nvm_valid_i,
   input  wire [5:0]  nvm_framing_i,
   output reg         nvm_wr_o,
   output reg  [5:0]  nvm_data_o,
   // Configuration and display outputs
   output reg  [7:0]  station_addr_o,
   output reg         register_proto_o,
   output reg         menu_allow_o,
   output reg  [5:0]  framing_o,
   output reg         respond_en_o,
   output reg  [7:0]  disp_value_o,
   output reg  [1:0]  disp_text_o,
   output reg  [1:0]  disp_proto_o
);

   // =======================================================================
   // States
   localparam [7:0] S_SAMPLE = 8'h01;
   localparam [7:0] S_CHECK  = 8'h02;
   localparam [7:0] S_HALT   = 8'h04;
   localparam [7:0] S_BAUD   = 8'h08;
   localparam [7:0] S_TRY    = 8'h10;
   localparam [7:0] S_SAVE   = 8'h20;
   localparam [7:0] S_DONE   = 8'h40;

   reg  [7:0]              state_q;
   reg  [7:0]              addr_q;
   reg  [3:0]              opt_q;
   reg                     valid_q;
   reg  [`BAC_FR_W-1:0]    det_q;
   reg  [1:0]              try_q;
   reg  [`BAC_RUN_W-1:0]   run_q;
   reg  [`BAC_RUN_W-1:0]   min_q;
   reg  [3:0]              pulses_q;
   reg                     rxd_q;
   reg  [8:0]              manual_q;
   reg                     fall_seen_q;

   wire                    reg_proto = opt_q[`BAC_OPT_PROTO];
   wire                    addr_ok;
   wire [`BAC_FR_W-1:0]    cand;
   reg  [2:0]              baud_idx;

   // =======================================================================
   // Address decode and range check
   // The switch bank is wired so position 1 is bit 7, giving binary weights.
   // Address 0 is refused only under the register protocol, 128 to 247 only under the other.
   assign addr_ok = reg_proto ?
      (addr_q >= `BAC_REG_ADR_MIN && addr_q <= `BAC_REG_ADR_MAX) :
      (addr_q <= `BAC_BLD_ADR_MAX);

   // =======================================================================
   // Baud classification from the shortest low run seen on the line
   // Thresholds sit midway between neighbouring bit times.
   // Traffic that never holds a single low bit reads too slow; the trial loop
   // then runs out of candidates and measures the baud again.
   always @* begin
      if (min_q > (`BAC_BIT_9600 + `BAC_BIT_19200) / 2)
         baud_idx = `BAC_BAUD_9600;
      else if (min_q > (`BAC_BIT_19200 + `BAC_BIT_38400) / 2)
         baud_idx = `BAC_BAUD_19200;
      else if (min_q > (`BAC_BIT_38400 + `BAC_BIT_57600) / 2)
         baud_idx = `BAC_BAUD_38400;
      else if (min_q > (`BAC_BIT_57600 + `BAC_BIT_76800) / 2)
         baud_idx = `BAC_BAUD_57600;
      else if (min_q > (`BAC_BIT_76800 + `BAC_BIT_115200) / 2)
         baud_idx = `BAC_BAUD_76800;
      else
         baud_idx = `BAC_BAUD_115200;
   end

   // Register protocol candidates in order: even/1, odd/1, none/2.
   assign cand = reg_proto ?
      {(try_q == `BAC_TRY_LAST),
       (try_q == 2'h0) ? `BAC_PAR_EVEN :
       (try_q == 2'h1) ? `BAC_PAR_ODD : `BAC_PAR_NONE,
       baud_idx} :
      {1'b0, `BAC_PAR_NONE, `BAC_BAUD_9600};

   // =======================================================================
   // Sequencer
   // Detection runs at most once per reset. A framing held in the store skips
   // it, so moving the node to a bus with other framing needs the manual
   // setting or a store that no longer reports a saved framing.
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q  <= S_SAMPLE;
         addr_q   <= 8'h00;
         opt_q    <= 4'h0;
         valid_q  <= 1'b0;
         det_q    <= {`BAC_FR_W{1'b0}};
         try_q    <= 2'h0;
         run_q    <= {`BAC_RUN_W{1'b0}};
         min_q    <= `BAC_RUN_MAX;
         pulses_q <= 4'h0;
         rxd_q    <= 1'b1;
         fall_seen_q <= 1'b0;
         nvm_wr_o <= 1'b0;
         nvm_data_o <= {`BAC_FR_W{1'b0}};
      end else begin
         rxd_q    <= rxd_i;
         nvm_wr_o <= 1'b0;
         case (state_q)
            S_SAMPLE: begin
               // Switches are caught once here and never again until reset.
               addr_q  <= address_switch_bank_i;
               opt_q   <= option_switch_bank_i;
               state_q <= S_CHECK;
            end
            S_CHECK: begin
               // A saved framing is trusted as it stands; no new save follows.
               valid_q <= addr_ok;
               if (!addr_ok)
                  state_q <= S_HALT;
               else if (nvm_valid_i) begin
                  det_q   <= nvm_framing_i;
                  state_q <= S_DONE;
               end else begin
                  min_q    <= `BAC_RUN_MAX;
                  pulses_q <= 4'h0;
                  try_q    <= 2'h0;
                  fall_seen_q <= 1'b0;
                  state_q  <= reg_proto ? S_BAUD : S_TRY;
               end
            end
            S_BAUD: begin
               // Shortest low run over several pulses is one bit time.
               if (!rxd_i && run_q != `BAC_RUN_MAX)
                  run_q <= run_q + 1'b1;
               // A run already low on entry would measure short, so counting
               // starts only at a falling edge seen in this state.
               if (!rxd_i && rxd_q) begin
                  run_q       <= {{(`BAC_RUN_W-1){1'b0}}, 1'b1};
                  fall_seen_q <= 1'b1;
               end
               if (rxd_i && !rxd_q && fall_seen_q) begin
                  run_q    <= {`BAC_RUN_W{1'b0}};
                  pulses_q <= pulses_q + 1'b1;
                  if (run_q < min_q)
                     min_q <= run_q;
                  if (pulses_q == `BAC_PULSES - 4'h1)
                     state_q <= S_TRY;
               end
            end
            S_TRY: begin
               // A framing error steps to the next candidate; a wrong baud also
               // shows as errors, so the baud is measured again after the last.
               det_q <= cand;
               if (msg_ok_i && msg_addr_i == addr_q)
                  state_q <= S_SAVE;
               else if (msg_err_i && reg_proto) begin
                  if (try_q == `BAC_TRY_LAST) begin
                     try_q    <= 2'h0;
                     min_q    <= `BAC_RUN_MAX;
                     pulses_q <= 4'h0;
                     fall_seen_q <= 1'b0;
                     state_q  <= S_BAUD;
                  end else
                     try_q <= try_q + 2'h1;
               end
            end
            S_SAVE: begin
               nvm_wr_o   <= 1'b1;
               nvm_data_o <= det_q;
               state_q    <= S_DONE;
            end
            S_DONE: state_q <= S_DONE;
            // An invalid address stops here: nothing is detected or saved.
            S_HALT: state_q <= S_HALT;
            default: state_q <= S_SAMPLE;
         endcase
      end
   end

   // =======================================================================
   // Outputs
   always @(posedge clk_i) begin
      if (rst_i) begin
         station_addr_o   <= 8'h00;
         register_proto_o <= 1'b0;
         menu_allow_o     <= 1'b0;
         framing_o        <= {`BAC_FR_W{1'b0}};
         respond_en_o     <= 1'b0;
         disp_value_o     <= 8'h00;
         disp_text_o      <= `BAC_TXT_NONE;
         disp_proto_o     <= `BAC_TAG_BLD;
      end else begin
         station_addr_o   <= addr_q;
         register_proto_o <= reg_proto;
         // The menu gate follows the display pin live; the switch is latched.
         menu_allow_o     <= opt_q[`BAC_OPT_MENU] && display_present_i;
         // A manual setting overrides detection for unsupported framings.
         framing_o        <= manual_q[`BAC_MAN_EN] ? manual_q[`BAC_FR_W-1:0] : det_q;
         // Requests go unanswered until a framing is settled.
         respond_en_o     <= (state_q == S_DONE) || manual_q[`BAC_MAN_EN];
         disp_value_o     <= addr_q;
         disp_proto_o     <= reg_proto ? `BAC_TAG_REG : `BAC_TAG_BLD;
         // No tag is shown until the sampled address has been checked.
         if (state_q == S_SAMPLE)
            disp_text_o <= `BAC_TXT_NONE;
         else if (state_q == S_CHECK)
            disp_text_o <= addr_ok ? `BAC_TXT_ADDR : `BAC_TXT_ERR;
         else
            disp_text_o <= valid_q ? `BAC_TXT_ADDR : `BAC_TXT_ERR;
      end
   end

   // =======================================================================
   // Wishbone slave: ack one cycle after the request, write on the ack edge.
   // The master must drop cyc or stb after the ack: a request held past it is
   // answered again, and a held write then lands twice.
   wire        req = wb_cyc_i && wb_stb_i;
   reg  [31:0] rd_d;

   always @* begin
      rd_d = 32'h00000000;
      // Reads have no side effects, so a repeated read is harmless.
      case (wb_adr_i)
         `BAC_REG_STATUS: begin
            rd_d[7:0]            = addr_q;
            rd_d[`BAC_ST_VALID]  = valid_q;
            rd_d[`BAC_ST_PROTO]  = reg_proto;
            rd_d[`BAC_ST_MENU]   = menu_allow_o;
            rd_d[`BAC_ST_DONE]   = (state_q == S_DONE);
            rd_d[`BAC_ST_DETECT] = (state_q == S_BAUD) || (state_q == S_TRY);
            rd_d[`BAC_ST_HALT]   = (state_q == S_HALT);
         end
         `BAC_REG_FRAMING: rd_d[`BAC_FR_W-1:0] = det_q;
         `BAC_REG_MANUAL:  rd_d[8:0] = manual_q;
         default: rd_d = 32'h00000000;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         manual_q <= 9'h000;
      end else begin
         wb_ack_o <= req && !wb_ack_o;
         if (req && !wb_ack_o)
            wb_dat_o <= rd_d;
         // Only the framing bits and the enable bit are kept; other bits read 0.
         if (req && wb_ack_o && wb_we_i && wb_adr_i == `BAC_REG_MANUAL) begin
            if (wb_sel_i[0])
               manual_q[7:0] <= {2'h0, wb_dat_i[`BAC_FR_W-1:0]};
            if (wb_sel_i[1])
               manual_q[8] <= wb_dat_i[`BAC_MAN_EN];
         end
      end
   end

endmodule

// ---- bench/bac_master_model.sv ----
// Behavioural bus master on the serial side, with its message engine reports.
// Assumes the bench calls one task at a time, right after a rising clock edge.
module bac_master_model (
   // Clock
   input  logic       clk_i,
   // Serial line and message reports
   output logic       rxd_o,
   output logic       msg_ok_o,
   output logic       msg_err_o,
   output logic [7:0] msg_addr_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rxd_o = 1'b1;
      msg_ok_o = 1'b0;
      msg_err_o = 1'b0;
      msg_addr_o = 8'h5a;
   end
   // The master sends eight low pulses of bit_len clocks each, then leaves the line idle high.
   task automatic pulses(input int bit_len);
      repeat (8) begin
         @(posedge clk_i);
         rxd_o <= 1'b0;
         repeat (bit_len) @(posedge clk_i);
         rxd_o <= 1'b1;
         repeat (bit_len - 1) @(posedge clk_i);
      end
   endtask
   // The address is scrambled once a report is over, so it is never reused.
   task automatic msg(input logic ok, input logic [7:0] adr);
      @(posedge clk_i);
      msg_ok_o <= ok;
      msg_err_o <= !ok;
      msg_addr_o <= adr;
      @(posedge clk_i);
      msg_ok_o <= 1'b0;
      msg_err_o <= 1'b0;
      msg_addr_o <= ~adr;
   endtask
endmodule

// ---- bench/bac_config_checker.sv ----
// Assertions on the ports of the configuration loader.
// Assumes the range and tag codes of bac_defines.vh.
`include "bac_defines.vh"
module bac_config_checker (
   // Clock, reset and bus
   input logic       clk_i,
   input logic       rst_i,
   input logic       wb_cyc_i,
   input logic       wb_stb_i,
   input logic       wb_ack_o,
   // Switches, messages and results
   input logic [3:0] option_switch_bank_i,
   input logic       display_present_i,
   input logic       msg_ok_i,
   input logic [7:0] msg_addr_i,
   input logic       nvm_wr_o,
   input logic [5:0] nvm_data_o,
   input logic [7:0] station_addr_o,
   input logic       register_proto_o,
   input logic       menu_allow_o,
   input logic [5:0] framing_o,
   input logic       respond_en_o,
   input logic [7:0] disp_value_o,
   input logic [1:0] disp_text_o,
   input logic [1:0] disp_proto_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire bad_w = register_proto_o ? (station_addr_o < `BAC_REG_ADR_MIN
      || station_addr_o > `BAC_REG_ADR_MAX) : (station_addr_o > `BAC_BLD_ADR_MAX);
   // =====================================================================
   // Assertions
   chk_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus answer missing");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus answer too long");
   chk_text_valid: assert property (
      disp_text_o != `BAC_TXT_NONE |-> disp_text_o == (bad_w ? `BAC_TXT_ERR : `BAC_TXT_ADDR))
      else $error("display tag wrong for address");
   chk_disp_show: assert property (
      disp_text_o != `BAC_TXT_NONE |-> disp_value_o == station_addr_o
      && disp_proto_o == (register_proto_o ? `BAC_TAG_REG : `BAC_TAG_BLD))
      else $error("display value or protocol tag wrong");
   chk_menu_gate: assert property (
      menu_allow_o |-> $past(display_present_i) && $past(option_switch_bank_i[0]))
      else $error("menu allowed without switch and display");
   chk_save_cause: assert property (
      nvm_wr_o |-> $past(msg_ok_i, 2) && $past(msg_addr_i, 2) == station_addr_o)
      else $error("store write without own message");
   chk_save_data: assert property (nvm_wr_o |-> nvm_data_o == framing_o ##1 respond_en_o)
      else $error("store write data or completion wrong");
   chk_done_held: assert property (respond_en_o |=> respond_en_o && !nvm_wr_o)
      else $error("detection restarted");
   chk_halt_quiet: assert property (
      disp_text_o == `BAC_TXT_ERR |-> !respond_en_o && !nvm_wr_o)
      else $error("detection ran on a bad address");
   chk_addr_held: assert property (
      !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3) |-> $stable(station_addr_o))
      else $error("station address changed after power-up");
endmodule

bind bac_config bac_config_checker u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .option_switch_bank_i(option_switch_bank_i),
   .display_present_i(display_present_i), .msg_ok_i(msg_ok_i), .msg_addr_i(msg_addr_i),
   .nvm_wr_o(nvm_wr_o), .nvm_data_o(nvm_data_o), .station_addr_o(station_addr_o),
   .register_proto_o(register_proto_o), .menu_allow_o(menu_allow_o), .framing_o(framing_o),
   .respond_en_o(respond_en_o), .disp_value_o(disp_value_o), .disp_text_o(disp_text_o),
   .disp_proto_o(disp_proto_o)
);

// ---- bench/testbench.sv ----
// Self-checking bench for the configuration loader.
// Assumes the serial-side master model and a 20 MHz clock.
`include "bac_defines.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  sel = 4'hf;
   logic        we = 1'b0;
   logic        cyc = 1'b0;
   logic [7:0]  asw = 8'h7f;
   logic [3:0]  osw = 4'h1;
   logic        dsp = 1'b1;
   logic        nv = 1'b0;
   logic [5:0]  nf = 6'h00;
   logic [31:0] rd;
   logic [8:0]  tbl [7] = '{9'h07f, 9'h080, 9'h000, 9'h100, 9'h1f7, 9'h1f8, 9'h101};
   logic        ok;
   wire  [31:0] rdat;
   wire         ack, rxd, mok, merr, nwr, prot, menu, resp;
   wire  [7:0]  madr, st, dval;
   wire  [5:0]  nd, fr;
   wire  [1:0]  dtxt, dprot;
   int          failures = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          writes = 0;

   bac_config DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
      .wb_ack_o(ack), .address_switch_bank_i(asw), .option_switch_bank_i(osw),
      .display_present_i(dsp), .rxd_i(rxd), .msg_ok_i(mok), .msg_err_i(merr),
      .msg_addr_i(madr), .nvm_valid_i(nv), .nvm_framing_i(nf), .nvm_wr_o(nwr),
      .nvm_data_o(nd), .station_addr_o(st), .register_proto_o(prot), .menu_allow_o(menu),
      .framing_o(fr), .respond_en_o(resp), .disp_value_o(dval), .disp_text_o(dtxt),
      .disp_proto_o(dprot));
   bac_master_model mdl (.clk_i(clk_i), .rxd_o(rxd), .msg_ok_o(mok), .msg_err_o(merr),
      .msg_addr_o(madr));

   initial begin
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      writes <= rst_i ? 0 : writes + int'(nwr);
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("failures=%0d num_checks=%0d", failures, num_checks);
      if (failures == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clk_i);
      cyc <= 1'b1;
      adr <= a;
      we <= w;
      wdat <= d;
      sel <= s;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
   endtask
   // The first loop takes its addresses from the table, refusals included; later power-ups give 8'hf7 and 8'h01 directly.
   task automatic power_up(input logic [7:0] a, input logic [3:0] o, input logic v,
                           input logic [5:0] f);
      @(posedge clk_i);
      rst_i <= 1'b1;
      asw <= a;
      osw <= o;
      nv <= v;
      nf <= f;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask

   initial begin
      repeat (2) @(posedge clk_i);
      foreach (tbl[i]) begin
         power_up(tbl[i][7:0], {2'b00, tbl[i][8], 1'b1}, 1'b0, 6'h00);
         ok = tbl[i][8] ? (tbl[i][7:0] inside {[8'h01:8'hf7]}) : (tbl[i][7:0] <= 8'h7f);
         chk(32'(st), 32'(tbl[i][7:0]));
         chk(32'(prot), 32'(tbl[i][8]));
         chk(32'(menu), 32'h1);
         chk(32'(dtxt), ok ? 32'(`BAC_TXT_ADDR) : 32'(`BAC_TXT_ERR));
         chk(32'(dprot), tbl[i][8] ? 32'(`BAC_TAG_REG) : 32'(`BAC_TAG_BLD));
         chk(32'(dval), 32'(tbl[i][7:0]));
         wb(4'h0, 1'b0, 32'h0, 4'hf);
         chk(rd, {18'h0, !ok, ok, 2'b01, tbl[i][8], ok, tbl[i][7:0]});
         asw <= ~tbl[i][7:0];
         mdl.msg(1'b1, tbl[i][7:0]);
         repeat (4) @(posedge clk_i);
         chk(32'(st), 32'(tbl[i][7:0]));
         if (!ok || !tbl[i][8]) chk(32'(writes), 32'(ok));
         chk(32'(resp), 32'(ok && !tbl[i][8]));
      end
      dsp <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(32'(menu), 32'h0);
      dsp <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         power_up(8'hf7, 4'h2, 1'b0, 6'h00);
         chk(32'(menu), 32'h0);
         mdl.pulses(i ? `BAC_BIT_115200 : `BAC_BIT_19200);
         repeat (4) @(posedge clk_i);
         chk(32'(fr), i ? 32'h0d : 32'h09);
         repeat (i + 1) mdl.msg(1'b0, 8'hf7);
         repeat (4) @(posedge clk_i);
         chk(32'(fr), i ? 32'h25 : 32'h11);
         chk(32'(resp), 32'h0);
         wb(4'h0, 1'b0, 32'h0, 4'hf);
         chk(rd, 32'h13f7);
         mdl.msg(1'b1, 8'h05);
         repeat (4) @(posedge clk_i);
         chk(32'(writes), 32'h0);
         repeat (2) mdl.msg(1'b1, 8'hf7);
         repeat (4) @(posedge clk_i);
         chk(32'(writes), 32'h1);
         chk(32'(resp), 32'h1);
         chk(32'(nd), i ? 32'h25 : 32'h11);
      end
      power_up(8'h01, 4'h2, 1'b1, 6'h0c);
      chk(32'(fr), 32'h0c);
      wb(4'h0, 1'b0, 32'h0, 4'hf);
      chk(rd, 32'hb01);
      wb(4'h4, 1'b1, 32'h3f, 4'hf);
      wb(4'h4, 1'b0, 32'h0, 4'hf);
      chk(rd, 32'h0c);
      wb(4'hc, 1'b0, 32'h0, 4'hf);
      chk(rd, 32'h0);
      wb(4'h8, 1'b1, 32'hffffffff, 4'hf);
      wb(4'h8, 1'b0, 32'h0, 4'hf);
      chk(rd, 32'h13f);
      wb(4'h8, 1'b1, 32'h0, 4'h1);
      wb(4'h8, 1'b0, 32'h0, 4'hf);
      chk(rd, 32'h100);
      chk(32'(writes), 32'h0);
      end_of_test();
   end
endmodule
